// file: src/pps_defs.svh
// Constants for the per-port power-state control block.
// Assumes inclusion from the package, the design modules and the bench.
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

`define PPS_NPORTS 4
`define PPS_UP_PORT 0
`define PPS_PS_D0 2'h0
`define PPS_PS_D3HOT 2'h3
`define PPS_CTX_KEPT_RST 1'h1

`endif

// file: src/pps_pkg.sv
// Types for the per-port power-state control block.
// Assumes pps_defs.svh on the include path.
`include "pps_defs.svh"

package pps_pkg;

    typedef enum logic [1:0] {
        PPS_D0_UNINIT = 2'h0,
        PPS_D0_ACTIVE = 2'h1,
        PPS_D3_HOT = 2'h2,
        PPS_D3_COLD = 2'h3
    } pps_state_e;

    // TLP classes seen by a bridge
    typedef enum logic [2:0] {
        PPS_TLP_CFG0 = 3'h0,
        PPS_TLP_MSG_SELF = 3'h1,
        PPS_TLP_CPL_SELF = 3'h2,
        PPS_TLP_CPL_THRU = 3'h3,
        PPS_TLP_OTHER_REQ = 3'h4
    } pps_tlp_e;

    // Handling decision for a TLP
    typedef enum logic [1:0] {
        PPS_ACT_NORMAL = 2'h0,
        PPS_ACT_UR = 2'h1,
        PPS_ACT_UC = 2'h2
    } pps_act_e;

endpackage

// file: src/pps_port_if.sv
// Signals between the top and one per-port state machine.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none

interface pps_port_if;
    import pps_pkg::*;
    logic psWrite;
    logic [1:0] psWrData;
    logic bridgeConfigured;
    logic powerRemoved;
    pps_state_e state;
    logic [1:0] powerStateField;

    modport ctl (
        output psWrite, psWrData, bridgeConfigured, powerRemoved,
        input state, powerStateField
    );
    modport fsm (
        input psWrite, psWrData, bridgeConfigured, powerRemoved,
        output state, powerStateField
    );
endinterface

`default_nettype wire

// file: src/pps_port_fsm.sv
// One port's power-state machine.
// Assumes the top feeds write strobes already decoded for this port.
`timescale 1ns/100ps
`default_nettype none
`include "pps_defs.svh"

module pps_port_fsm
    import pps_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Port control
    pps_port_if.fsm pif
);

    pps_state_e state_q, state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            PPS_D0_UNINIT: begin
                if (pif.bridgeConfigured) begin
                    state_d = PPS_D0_ACTIVE;
                end
            end
            PPS_D0_ACTIVE: begin
                if (pif.psWrite && pif.psWrData == `PPS_PS_D3HOT) begin
                    state_d = PPS_D3_HOT;
                end
            end
            PPS_D3_HOT: begin
                if (pif.powerRemoved) begin
                    state_d = PPS_D3_COLD;
                end else if (pif.psWrite && pif.psWrData == `PPS_PS_D0) begin
                    state_d = PPS_D0_UNINIT;
                end
            end
            // Only a fundamental reset leaves D3cold
            PPS_D3_COLD: begin
                state_d = PPS_D3_COLD;
            end
            default: begin
                state_d = PPS_D0_UNINIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= PPS_D0_UNINIT;
        end else begin
            state_q <= state_d;
        end
    end

    assign pif.state = state_q;
    assign pif.powerStateField = (state_q == PPS_D3_HOT ||
        state_q == PPS_D3_COLD) ? `PPS_PS_D3HOT : `PPS_PS_D0;

    property p_d3_entry;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == PPS_D0_ACTIVE && pif.psWrite &&
         pif.psWrData == `PPS_PS_D3HOT) |=> state_q == PPS_D3_HOT;
    endproperty
    a_d3_entry: assert property (p_d3_entry)
        else $error("no D3hot entry");

    property p_d0_return;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == PPS_D3_HOT && !pif.powerRemoved && pif.psWrite &&
         pif.psWrData == `PPS_PS_D0) |=> state_q == PPS_D0_UNINIT;
    endproperty
    a_d0_return: assert property (p_d0_return)
        else $error("no D0 return");

    property p_bad_enc;
        @(posedge clk_sys) disable iff (sys_rst)
        (pif.psWrite && pif.psWrData != `PPS_PS_D0 &&
         pif.psWrData != `PPS_PS_D3HOT && !pif.bridgeConfigured &&
         !pif.powerRemoved) |=> $stable(state_q);
    endproperty
    a_bad_enc: assert property (p_bad_enc)
        else $error("bad code moved");

    property p_configure;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == PPS_D0_UNINIT && pif.bridgeConfigured)
            |=> state_q == PPS_D0_ACTIVE;
    endproperty
    a_configure: assert property (p_configure)
        else $error("no activate");

endmodule

`default_nettype wire

// file: src/pps_power_ctl.sv
// Per-port device power-state control for a switch's bridges.
// Assumes TLPs arrive pre-classified, one per port per cycle, and that
// software configuration writes arrive already decoded per port.
//
// Behaviour
// - A downstream port's power state affects only that port.
// - A port in D3hot asks its link for L1 regardless of other ports.
// - Upstream low power plus all acks puts the whole switch low.
// - Each port has four states: D0 uninit, D0 active, D3hot, D3cold.
// - Reset enters D0 uninit; bridge configuration moves it to D0 active.
// - D0 active goes to D3hot on a write of the D3hot code.
// - D3hot returns to D0 uninit on a write of the D0 code.
// - Leaving D3hot resets nothing and the context-kept flag reads set.
// - In D3hot type 0 configuration requests complete normally.
// - In D3hot messages to the bridge are processed.
// - In D3hot other primary-side requests are unsupported.
// - In D3hot TLP-reception errors are reported as in D0.
// - In D3hot non-TLP errors are dropped.
// - In D3hot completions to the bridge are unexpected.
// - In D3hot pass-through completions route as in D0.
// - In D3hot secondary-side requests are unsupported.
`timescale 1ns/100ps
`default_nettype none
`include "pps_defs.svh"

module pps_power_ctl
    import pps_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Software power-state writes and bridge configuration, per port; power removal shared
    input wire logic [`PPS_NPORTS-1:0] psWrite,
    input wire logic [`PPS_NPORTS*2-1:0] psWrData,
    input wire logic [`PPS_NPORTS-1:0] bridgeConfigured,
    input wire logic powerRemoved,
    // Aggregated PME_TO_Ack seen on all active downstream ports
    input wire logic pmeToAckDone,
    // Primary-side TLP, per port
    input wire logic [`PPS_NPORTS-1:0] priValid,
    input wire logic [`PPS_NPORTS*3-1:0] priClass,
    // Secondary-side TLP, per port
    input wire logic [`PPS_NPORTS-1:0] secValid,
    input wire logic [`PPS_NPORTS*3-1:0] secClass,
    // Error events, per port
    input wire logic [`PPS_NPORTS-1:0] tlpErrEvent,
    input wire logic [`PPS_NPORTS-1:0] otherErrEvent,
    // Per-port status
    output logic [`PPS_NPORTS*2-1:0] portState,
    output logic [`PPS_NPORTS*2-1:0] power_state_field,
    output logic [`PPS_NPORTS-1:0] context_kept_flag,
    output logic [`PPS_NPORTS-1:0] linkL1Req,
    // Per-port TLP decisions, registered
    output logic [`PPS_NPORTS-1:0] priDecValid,
    output logic [`PPS_NPORTS*2-1:0] priAction,
    output logic [`PPS_NPORTS-1:0] secDecValid,
    output logic [`PPS_NPORTS*2-1:0] secAction,
    output logic [`PPS_NPORTS-1:0] errMsgReq,
    // Whole-device low power
    output logic deviceLowPower
);

    // ------------------------------------------------------------
    // Decision functions
    // ------------------------------------------------------------
    // One function per side; each takes the D3hot flag so D0 and D3hot use one code path
    function automatic pps_act_e priDecide(input logic d3,
                                           input logic [2:0] cls);
        pps_act_e act;
        act = PPS_ACT_NORMAL;
        if (d3) begin
            case (cls)
                PPS_TLP_CFG0: act = PPS_ACT_NORMAL;
                PPS_TLP_MSG_SELF: act = PPS_ACT_NORMAL;
                PPS_TLP_CPL_SELF: act = PPS_ACT_UC;
                PPS_TLP_CPL_THRU: act = PPS_ACT_NORMAL;
                default: act = PPS_ACT_UR;
            endcase
        end
        return act;
    endfunction

    function automatic pps_act_e secDecide(input logic d3,
                                           input logic [2:0] cls);
        pps_act_e act;
        act = PPS_ACT_NORMAL;
        if (d3) begin
            case (cls)
                PPS_TLP_CPL_THRU: act = PPS_ACT_NORMAL;
                PPS_TLP_CPL_SELF: act = PPS_ACT_UC;
                default: act = PPS_ACT_UR;
            endcase
        end
        return act;
    endfunction

    // ------------------------------------------------------------
    // Per-port machines
    // ------------------------------------------------------------
    logic [`PPS_NPORTS-1:0] inD3;
    logic [`PPS_NPORTS-1:0] priDecValid_d, priDecValid_q;
    logic [`PPS_NPORTS-1:0] secDecValid_d, secDecValid_q;
    logic [`PPS_NPORTS*2-1:0] priAction_d, priAction_q;
    logic [`PPS_NPORTS*2-1:0] secAction_d, secAction_q;
    logic [`PPS_NPORTS-1:0] errMsg_d, errMsg_q;
    logic [`PPS_NPORTS-1:0] l1_d, l1_q;
    logic devLow_d, devLow_q;

    generate
        for (genvar p = 0; p < `PPS_NPORTS; p++) begin : g_port
            pps_port_if pif ();
            assign pif.psWrite = psWrite[p];
            assign pif.psWrData = psWrData[2*p +: 2];
            assign pif.bridgeConfigured = bridgeConfigured[p];
            assign pif.powerRemoved = powerRemoved;
            pps_port_fsm u_fsm (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .pif(pif)
            );
            assign inD3[p] = (pif.state == PPS_D3_HOT);
            assign portState[2*p +: 2] = pif.state;
            assign power_state_field[2*p +: 2] = pif.powerStateField;
        end
    endgenerate

    // ------------------------------------------------------------
    // Decisions and link requests
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < `PPS_NPORTS; p++) begin
            priDecValid_d[p] = priValid[p];
            secDecValid_d[p] = secValid[p];
            priAction_d[2*p +: 2] = priDecide(inD3[p], priClass[3*p +: 3]);
            secAction_d[2*p +: 2] = secDecide(inD3[p], secClass[3*p +: 3]);
            // TLP errors always report; others dropped in D3hot
            errMsg_d[p] = tlpErrEvent[p] | (otherErrEvent[p] & ~inD3[p]);
            l1_d[p] = inD3[p];
        end
        devLow_d = inD3[`PPS_UP_PORT] & pmeToAckDone;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            priDecValid_q <= '0;
            secDecValid_q <= '0;
            priAction_q <= '0;
            secAction_q <= '0;
            errMsg_q <= '0;
            l1_q <= '0;
            devLow_q <= 1'b0;
        end else begin
            priDecValid_q <= priDecValid_d;
            secDecValid_q <= secDecValid_d;
            priAction_q <= priAction_d;
            secAction_q <= secAction_d;
            errMsg_q <= errMsg_d;
            l1_q <= l1_d;
            devLow_q <= devLow_d;
        end
    end

    assign priDecValid = priDecValid_q;
    assign secDecValid = secDecValid_q;
    assign priAction = priAction_q;
    assign secAction = secAction_q;
    assign errMsgReq = errMsg_q;
    assign linkL1Req = l1_q;
    assign deviceLowPower = devLow_q;
    assign context_kept_flag = {`PPS_NPORTS{`PPS_CTX_KEPT_RST}};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_l1_follow;
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 linkL1Req == $past(inD3);
    endproperty
    a_l1_follow: assert property (p_l1_follow)
        else $error("L1 request off");

    property p_dev_low;
        @(posedge clk_sys) disable iff (sys_rst)
        (inD3[`PPS_UP_PORT] && pmeToAckDone) |=> deviceLowPower;
    endproperty
    a_dev_low: assert property (p_dev_low)
        else $error("no device low");

    // Device stays up unless upstream sleeps and acks are in
    property p_dev_up;
        @(posedge clk_sys) disable iff (sys_rst)
        (!inD3[`PPS_UP_PORT] || !pmeToAckDone) |=> !deviceLowPower;
    endproperty
    a_dev_up: assert property (p_dev_up)
        else $error("device low too early");

    property p_ctx;
        @(posedge clk_sys) context_kept_flag == '1;
    endproperty
    a_ctx: assert property (p_ctx)
        else $error("context flag clear");

    // Same checks on every port, so any port the traffic uses is watched
    generate
        for (genvar p = 0; p < `PPS_NPORTS; p++) begin : g_chk
            sequence s_d3_enter;
                !inD3[p] ##1 inD3[p];
            endsequence

            property p_l1_on_d3;
                @(posedge clk_sys) disable iff (sys_rst)
                s_d3_enter |=> linkL1Req[p];
            endproperty
            a_l1_on_d3: assert property (p_l1_on_d3)
                else $error("no L1 request after D3hot");

            property p_cfg0_ok;
                @(posedge clk_sys) disable iff (sys_rst)
                (priValid[p] && priClass[3*p +: 3] == PPS_TLP_CFG0)
                    |=> priDecValid[p] &&
                    priAction[2*p +: 2] == PPS_ACT_NORMAL;
            endproperty
            a_cfg0_ok: assert property (p_cfg0_ok)
                else $error("cfg0 refused");

            property p_msg_self;
                @(posedge clk_sys) disable iff (sys_rst)
                (priValid[p] && priClass[3*p +: 3] == PPS_TLP_MSG_SELF)
                    |=> priAction[2*p +: 2] == PPS_ACT_NORMAL;
            endproperty
            a_msg_self: assert property (p_msg_self)
                else $error("own message refused");

            property p_other_ur;
                @(posedge clk_sys) disable iff (sys_rst)
                (inD3[p] && priValid[p] &&
                 priClass[3*p +: 3] == PPS_TLP_OTHER_REQ)
                    |=> priAction[2*p +: 2] == PPS_ACT_UR;
            endproperty
            a_other_ur: assert property (p_other_ur)
                else $error("not UR");

            // Outside D3hot no primary-side TLP is refused
            property p_d0_normal;
                @(posedge clk_sys) disable iff (sys_rst)
                (!inD3[p] && priValid[p])
                    |=> priDecValid[p] &&
                    priAction[2*p +: 2] == PPS_ACT_NORMAL;
            endproperty
            a_d0_normal: assert property (p_d0_normal)
                else $error("refused outside D3hot");

            property p_cpl_uc;
                @(posedge clk_sys) disable iff (sys_rst)
                (inD3[p] && priValid[p] &&
                 priClass[3*p +: 3] == PPS_TLP_CPL_SELF)
                    |=> priAction[2*p +: 2] == PPS_ACT_UC;
            endproperty
            a_cpl_uc: assert property (p_cpl_uc)
                else $error("not UC");

            property p_pri_thru;
                @(posedge clk_sys) disable iff (sys_rst)
                (priValid[p] && priClass[3*p +: 3] == PPS_TLP_CPL_THRU)
                    |=> priAction[2*p +: 2] == PPS_ACT_NORMAL;
            endproperty
            a_pri_thru: assert property (p_pri_thru)
                else $error("primary completion not routed");

            property p_sec_thru;
                @(posedge clk_sys) disable iff (sys_rst)
                (secValid[p] && secClass[3*p +: 3] == PPS_TLP_CPL_THRU)
                    |=> secAction[2*p +: 2] == PPS_ACT_NORMAL;
            endproperty
            a_sec_thru: assert property (p_sec_thru)
                else $error("secondary completion not routed");

            property p_sec_ur;
                @(posedge clk_sys) disable iff (sys_rst)
                (inD3[p] && secValid[p] &&
                 secClass[3*p +: 3] == PPS_TLP_OTHER_REQ)
                    |=> secAction[2*p +: 2] == PPS_ACT_UR;
            endproperty
            a_sec_ur: assert property (p_sec_ur)
                else $error("sec not UR");

            property p_err_drop;
                @(posedge clk_sys) disable iff (sys_rst)
                (inD3[p] && otherErrEvent[p] && !tlpErrEvent[p])
                    |=> !errMsgReq[p];
            endproperty
            a_err_drop: assert property (p_err_drop)
                else $error("error not dropped");

            property p_err_tlp;
                @(posedge clk_sys) disable iff (sys_rst)
                tlpErrEvent[p] |=> errMsgReq[p];
            endproperty
            a_err_tlp: assert property (p_err_tlp)
                else $error("TLP error lost");
        end
    endgenerate

endmodule

`default_nettype wire

// file: bench/pps_link_partner.sv
// Model of the link partners and root behind the switch ports.
// Assumes the bench raises turnOff as the root's turn-off broadcast.
`timescale 1ns/100ps
`default_nettype none

module pps_link_partner #(
    parameter int ACK_DLY = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Root broadcast and link requests
    input wire logic turnOff,
    input wire logic [3:0] linkL1Req,
    // Aggregated acknowledge
    output logic pmeToAckDone
);
    logic [3:0] waitCnt_q;
    logic [3:0] waitCnt_d;

    always_comb begin
        waitCnt_d = waitCnt_q;
        if (!turnOff || !linkL1Req[0]) begin
            waitCnt_d = 4'h0;
        end else if (waitCnt_q != ACK_DLY[3:0]) begin
            waitCnt_d = waitCnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            waitCnt_q <= 4'h0;
        end else begin
            waitCnt_q <= waitCnt_d;
        end
    end

    // Drops at once when the broadcast ends
    assign pmeToAckDone = turnOff && (waitCnt_q == ACK_DLY[3:0]);
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the per-port power-state control block.
// Assumes design sources and the link partner model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "pps_defs.svh"

module tb_top;
    import pps_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] psWrite = 4'h0;
    logic [7:0] psWrData = 8'h00;
    logic [3:0] bridgeConfigured = 4'h0;
    logic powerRemoved = 1'b0;
    logic turnOff = 1'b0;
    logic pmeToAckDone;
    logic [3:0] priValid = 4'h0;
    logic [3:0] secValid = 4'h0;
    logic [11:0] priClass = 12'h000;
    logic [11:0] secClass = 12'h000;
    logic [3:0] tlpErrEvent = 4'h0;
    logic [3:0] otherErrEvent = 4'h0;
    logic [7:0] portState, power_state_field, priAction, secAction;
    logic [3:0] context_kept_flag, linkL1Req, priDecValid;
    logic [3:0] secDecValid, errMsgReq;
    logic deviceLowPower;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    pps_power_ctl pps_power_ctl_inst (.clk_sys, .sys_rst, .psWrite,
        .psWrData, .bridgeConfigured, .powerRemoved, .pmeToAckDone,
        .priValid, .priClass, .secValid, .secClass, .tlpErrEvent,
        .otherErrEvent, .portState, .power_state_field,
        .context_kept_flag, .linkL1Req, .priDecValid, .priAction,
        .secDecValid, .secAction, .errMsgReq, .deviceLowPower);

    pps_link_partner pps_link_partner_inst (.clk_sys, .sys_rst,
        .turnOff, .linkL1Req, .pmeToAckDone);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task wr(input int p, input logic [1:0] code);
        @(posedge clk_sys);
        psWrite <= 4'h1 << p;
        psWrData <= {6'h00, code} << (2 * p);
        @(posedge clk_sys);
        psWrite <= 4'h0;
        #1;
    endtask

    task cfg(input int p);
        @(posedge clk_sys);
        bridgeConfigured <= 4'h1 << p;
        @(posedge clk_sys);
        bridgeConfigured <= 4'h0;
        #1;
    endtask

    // One TLP, decision judged one cycle later
    task tlp(input int p, input bit sec, input logic [2:0] cls,
             input logic [1:0] act);
        @(posedge clk_sys);
        if (sec) begin
            secValid <= 4'h1 << p;
            secClass <= {9'h000, cls} << (3 * p);
        end else begin
            priValid <= 4'h1 << p;
            priClass <= {9'h000, cls} << (3 * p);
        end
        @(posedge clk_sys);
        secValid <= 4'h0;
        priValid <= 4'h0;
        #1;
        chk(sec ? secDecValid : priDecValid, 4'h1 << p);
        chk(sec ? secAction[2*p+:2] : priAction[2*p+:2], act);
    endtask

    task errEv(input int p, input bit fromTlp, input logic exp);
        @(posedge clk_sys);
        if (fromTlp) begin
            tlpErrEvent <= 4'h1 << p;
        end else begin
            otherErrEvent <= 4'h1 << p;
        end
        @(posedge clk_sys);
        tlpErrEvent <= 4'h0;
        otherErrEvent <= 4'h0;
        #1;
        chk(errMsgReq, exp ? 4'h1 << p : 4'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk(portState, 8'h00);
        chk(power_state_field, 8'h00);
        chk(context_kept_flag, 4'hf);
        chk(linkL1Req | errMsgReq, 4'h0);
        chk(deviceLowPower, 1'b0);
    endtask

    task t_config;
        wr(1, `PPS_PS_D3HOT);
        chk(portState[3:2], PPS_D0_UNINIT);
        for (int p = 0; p < 4; p++) begin
            cfg(p);
            chk(portState[2*p+:2], PPS_D0_ACTIVE);
        end
        wr(1, 2'h1);
        wr(1, 2'h2);
        chk(portState, 8'h55);
    endtask

    task t_d3hot;
        wr(1, `PPS_PS_D3HOT);
        chk(portState, 8'h59);
        chk(power_state_field, 8'h0c);
        @(posedge clk_sys);
        #1;
        chk(linkL1Req, 4'h2);
    endtask

    task t_tlps;
        logic [1:0] pa [5] = '{PPS_ACT_NORMAL, PPS_ACT_NORMAL,
            PPS_ACT_UC, PPS_ACT_NORMAL, PPS_ACT_UR};
        for (int c = 0; c < 5; c++) begin
            tlp(1, 1'b0, 3'(c), pa[c]);
            tlp(2, 1'b0, 3'(c), PPS_ACT_NORMAL);
        end
        tlp(1, 1'b1, PPS_TLP_OTHER_REQ, PPS_ACT_UR);
        tlp(1, 1'b1, PPS_TLP_CFG0, PPS_ACT_UR);
        tlp(1, 1'b1, PPS_TLP_CPL_THRU, PPS_ACT_NORMAL);
    endtask

    task t_errors;
        errEv(1, 1'b1, 1'b1);
        errEv(1, 1'b0, 1'b0);
        errEv(2, 1'b0, 1'b1);
    endtask

    task t_wake;
        wr(1, `PPS_PS_D0);
        chk(portState[3:2], PPS_D0_UNINIT);
        chk(context_kept_flag, 4'hf);
        tlp(1, 1'b0, PPS_TLP_OTHER_REQ, PPS_ACT_NORMAL);
        chk(linkL1Req, 4'h0);
    endtask

    task t_upstream;
        wr(0, `PPS_PS_D3HOT);
        @(posedge clk_sys);
        turnOff <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(deviceLowPower, 1'b0);
        for (int i = 0; i < 20 && deviceLowPower !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(deviceLowPower, 1'b1);
        chk(portState[5:4], PPS_D0_ACTIVE);
        @(posedge clk_sys);
        turnOff <= 1'b0;
        wr(0, `PPS_PS_D0);
        @(posedge clk_sys);
        #1;
        chk(deviceLowPower, 1'b0);
    endtask

    task t_cold;
        wr(2, `PPS_PS_D3HOT);
        @(posedge clk_sys);
        powerRemoved <= 1'b1;
        @(posedge clk_sys);
        powerRemoved <= 1'b0;
        #1;
        chk(portState[5:4], PPS_D3_COLD);
        chk(portState[3:2], PPS_D0_UNINIT);
        wr(2, `PPS_PS_D0);
        chk(portState[5:4], PPS_D3_COLD);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        t_reset;
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done;
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        t_reset;
        t_config;
        t_d3hot;
        t_tlps;
        t_errors;
        t_wake;
        t_upstream;
        t_cold;
        test_done;
    end
endmodule

`default_nettype wire
